// ===== design/infilt_pkg.sv
// constants and types shared by the input conditioning block
package infilt_pkg;

	// timing
	localparam int unsigned CLK_PERIOD_PS = 5000;
	localparam int unsigned FILTER_STEP_MS = 1;
	localparam int unsigned TICK_CYCLES = (FILTER_STEP_MS * 1000000000) / CLK_PERIOD_PS;

	// filter values in milliseconds
	localparam logic [3:0] FILT_DEFAULT_MS = 4'h3;
	localparam logic [3:0] FILT_FIXED_MS = 4'h3;
	localparam logic [3:0] FILT_MIN_MS = 4'h3;
	localparam logic [3:0] FILT_REJECT_MARGIN_MS = 4'h2;
	localparam logic [3:0] FILT_PASS_MARGIN_MS = 4'h1;

	// pin layout
	localparam int unsigned GROUP_COUNT = 4;
	localparam int unsigned PINS_PER_GROUP = 2;
	localparam int unsigned CONFIG_PINS = GROUP_COUNT * PINS_PER_GROUP;
	localparam int unsigned MAX_CHANNELS = 8;

	// analog scale
	localparam int unsigned SAMPLE_W = 10;
	localparam logic [9:0] SAMPLE_MAX = 10'h3e8;
	localparam int unsigned RESULT_W = 16;
	localparam int unsigned AVG_W = 8;
	localparam int unsigned SUM_W = 18;

	// register byte addresses
	localparam logic [7:0] FILT_CFG_ADDR = 8'h00;
	localparam logic [7:0] SPECIAL_ADDR = 8'h04;
	localparam logic [7:0] ANALOG_SEL_ADDR = 8'h08;
	localparam logic [7:0] AVG_LO_ADDR = 8'h0c;
	localparam logic [7:0] AVG_HI_ADDR = 8'h10;
	localparam logic [7:0] IMAGE_ADDR = 8'h14;
	localparam logic [7:0] RESULT_BASE_ADDR = 8'h20;

	// reset values
	localparam logic [15:0] FILT_CFG_RESET = 16'h3333;
	localparam logic [3:0] SPECIAL_RESET = 4'h0;
	localparam logic [7:0] ANALOG_SEL_RESET = 8'h00;
	localparam logic [31:0] AVG_RESET = 32'h0000_0000;

	// per-pin filter setting
	typedef struct packed {
		logic [3:0] value_ms;
		logic bypass;
	} filt_cfg_type;

endpackage

// ===== design/pulse_filter.sv
// pulse-width noise filter for one discrete input
`timescale 1ns/1ps
`default_nettype none
module pulse_filter
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tick,
	input wire logic din,
	input wire infilt_pkg::filt_cfg_type cfg,
	output logic dout
);
	logic dout_q;
	logic dout_d;
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	logic [3:0] cnt_inc;

	assign dout = dout_q;

	always_comb
	begin
		cnt_inc = cnt_q + 4'h1;
		dout_d = dout_q;
		cnt_d = cnt_q;
		if (cfg.bypass || cfg.value_ms == 4'h0)
		begin
			dout_d = din;
			cnt_d = 4'h0;
		end
		else if (din == dout_q)
		begin
			// pulse ended early: discard what was counted
			cnt_d = 4'h0;
		end
		else if (tick)
		begin
			// accept after value-1 whole ticks: a pulse of value ms always
			// spans that many, one under value-2 ms never does
			if (cnt_inc >= cfg.value_ms - infilt_pkg::FILT_PASS_MARGIN_MS)
			begin
				dout_d = din;
				cnt_d = 4'h0;
			end
			else
			begin
				cnt_d = cnt_inc;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dout_q <= 1'b0;
			cnt_q <= 4'h0;
		end
		else
		begin
			dout_q <= dout_d;
			cnt_q <= cnt_d;
		end
	end
endmodule
`default_nettype wire

// ===== design/moving_average.sv
// per-scan moving average of one analog channel
`timescale 1ns/1ps
`default_nettype none
module moving_average
#(
	parameter int unsigned DEPTH = 256
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic sample_stb,
	input wire logic [9:0] sample,
	input wire logic [7:0] count,
	output logic [9:0] result
);
	localparam int unsigned PTR_W = $clog2(DEPTH);

	logic [9:0] ring_q [DEPTH];
	logic [9:0] ring_d [DEPTH];
	logic [PTR_W-1:0] wptr_q;
	logic [PTR_W-1:0] wptr_d;
	logic [7:0] filled_q;
	logic [7:0] filled_d;
	logic [7:0] cnt_seen_q;
	logic [7:0] cnt_seen_d;
	logic [17:0] sum_q;
	logic [17:0] sum_d;
	logic [9:0] result_q;
	logic [9:0] result_d;
	logic [9:0] clip;
	logic [9:0] oldest;

	assign result = result_q;

	always_comb
	begin
		clip = (sample > infilt_pkg::SAMPLE_MAX) ? infilt_pkg::SAMPLE_MAX : sample;
		oldest = ring_q[wptr_q - PTR_W'(count)];
		ring_d = ring_q;
		wptr_d = wptr_q;
		filled_d = filled_q;
		sum_d = sum_q;
		cnt_seen_d = cnt_seen_q;
		result_d = result_q;
		if (sample_stb)
		begin
			ring_d[wptr_q] = clip;
			wptr_d = wptr_q + 1'b1;
			cnt_seen_d = count;
			if (count == 8'h00)
			begin
				result_d = clip;
				filled_d = 8'h00;
				sum_d = 18'h0_0000;
			end
			else
			begin
				if (count != cnt_seen_q)
				begin
					// new count: restart the window from this sample
					sum_d = 18'(clip);
					filled_d = 8'h01;
				end
				else if (filled_q >= count)
				begin
					sum_d = sum_q + 18'(clip) - 18'(oldest);
					filled_d = count;
				end
				else
				begin
					sum_d = sum_q + 18'(clip);
					filled_d = filled_q + 8'h01;
				end
				result_d = 10'(sum_d / 18'(filled_d));
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < DEPTH; i++)
			begin
				ring_q[i] <= 10'h000;
			end
			wptr_q <= '0;
			filled_q <= 8'h00;
			cnt_seen_q <= 8'h00;
			sum_q <= 18'h0_0000;
			result_q <= 10'h000;
		end
		else
		begin
			ring_q <= ring_d;
			wptr_q <= wptr_d;
			filled_q <= filled_d;
			cnt_seen_q <= cnt_seen_d;
			sum_q <= sum_d;
			result_q <= result_d;
		end
	end
endmodule
`default_nettype wire

// ===== design/input_conditioner.sv
// discrete input noise filter and analog averaging with apb registers
// Overview of operation
// - four independently set groups cover pins 0-7
// - group value is 0 or 3..15 ms
// - every group defaults to 3 ms
// - pins eight and up use fixed 3 ms
// - pulses shorter than value minus 2 ms rejected
// - value-2 to value ms may pass or not
// - pulses of full value always pass
// - group filter only in plain input mode
// - input image taken at end of scan
// - analog reading spans 0 to 1000
// - non-analog shared pins act as discrete inputs
// - discrete-configured shared pins are noise filtered
// - up to eight channels, eight read-only results
// - results refreshed once per scan
// - count n gives mean of last n
// - sum of n scan samples over n
// - channels sit on the highest-numbered pins
// - ac-supplied models have no analog channels
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module input_conditioner
#(
	parameter int unsigned NUM_INPUTS = 32,
	parameter int unsigned MODEL_CHANNELS = 8,
	parameter bit AC_SUPPLY = 1'b0,
	parameter int unsigned AVG_DEPTH = 256,
	parameter int unsigned TICK_CYCLES = infilt_pkg::TICK_CYCLES
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NUM_INPUTS-1:0] pin_level,
	input wire logic [infilt_pkg::MAX_CHANNELS-1:0][9:0] adc_sample,
	input wire logic scan_end,
	output logic [NUM_INPUTS-1:0] input_image
);
	// channels present on this model
	localparam int unsigned CHANNELS = AC_SUPPLY ? 0 : MODEL_CHANNELS;
	localparam int unsigned FIRST_ANALOG_PIN = NUM_INPUTS - CHANNELS;
	localparam int unsigned TICK_W = $clog2(TICK_CYCLES + 1);

	////////////////////////////////////////////////////////////////////////
	// millisecond tick

	logic [TICK_W-1:0] tick_cnt_q;
	logic [TICK_W-1:0] tick_cnt_d;
	logic tick_q;
	logic tick_d;

	always_comb
	begin
		tick_d = 1'b0;
		tick_cnt_d = tick_cnt_q + 1'b1;
		if (tick_cnt_q == TICK_W'(TICK_CYCLES - 1))
		begin
			tick_cnt_d = '0;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tick_cnt_q <= '0;
			tick_q <= 1'b0;
		end
		else
		begin
			tick_cnt_q <= tick_cnt_d;
			tick_q <= tick_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// configuration registers and apb slave

	logic [15:0] filt_cfg_q;
	logic [15:0] filt_cfg_d;
	logic [3:0] special_q;
	logic [3:0] special_d;
	logic [7:0] analog_sel_q;
	logic [7:0] analog_sel_d;
	logic [63:0] avg_q;
	logic [63:0] avg_d;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic pready_q;
	logic pready_d;
	logic pslverr_q;
	logic pslverr_d;
	logic [7:0] chan_mask;
	logic [infilt_pkg::MAX_CHANNELS-1:0][9:0] result;
	logic access;
	logic [2:0] res_idx;
	logic [3:0] wv;
	logic [NUM_INPUTS-1:0] input_image_q;

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign res_idx = paddr[4:2];

	// selection bits for channels the model lacks stay clear
	always_comb
	begin
		for (int k = 0; k < 8; k++)
		begin
			chan_mask[k] = (k < CHANNELS);
		end
	end

	always_comb
	begin
		access = psel && penable && !pready_q;
		filt_cfg_d = filt_cfg_q;
		special_d = special_q;
		analog_sel_d = analog_sel_q;
		avg_d = avg_q;
		prdata_d = prdata_q;
		pready_d = access;
		pslverr_d = 1'b0;
		wv = 4'h0;
		if (access && pwrite)
		begin
			case (paddr)
				infilt_pkg::FILT_CFG_ADDR:
				begin
					for (int g = 0; g < 4; g++)
					begin
						wv = pwdata[g*4 +: 4];
						// 1 and 2 ms are not selectable: taken as the minimum
						if (wv != 4'h0 && wv < infilt_pkg::FILT_MIN_MS)
						begin
							wv = infilt_pkg::FILT_MIN_MS;
						end
						filt_cfg_d[g*4 +: 4] = wv;
					end
				end
				infilt_pkg::SPECIAL_ADDR:
					special_d = pwdata[3:0];
				infilt_pkg::ANALOG_SEL_ADDR:
					analog_sel_d = pwdata[7:0] & chan_mask;
				infilt_pkg::AVG_LO_ADDR:
					avg_d[31:0] = pwdata;
				infilt_pkg::AVG_HI_ADDR:
					avg_d[63:32] = pwdata;
				default:
					// results and image are read-only
					pslverr_d = 1'b1;
			endcase
		end
		else if (access)
		begin
			prdata_d = 32'h0000_0000;
			case (paddr)
				infilt_pkg::FILT_CFG_ADDR:
					prdata_d[15:0] = filt_cfg_q;
				infilt_pkg::SPECIAL_ADDR:
					prdata_d[3:0] = special_q;
				infilt_pkg::ANALOG_SEL_ADDR:
					prdata_d[7:0] = analog_sel_q;
				infilt_pkg::AVG_LO_ADDR:
					prdata_d = avg_q[31:0];
				infilt_pkg::AVG_HI_ADDR:
					prdata_d = avg_q[63:32];
				infilt_pkg::IMAGE_ADDR:
					prdata_d = 32'(input_image_q);
				default:
				begin
					if (paddr[7:5] == infilt_pkg::RESULT_BASE_ADDR[7:5] && paddr[1:0] == 2'b00)
					begin
						prdata_d[9:0] = result[res_idx];
					end
					else
					begin
						pslverr_d = 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			filt_cfg_q <= infilt_pkg::FILT_CFG_RESET;
			special_q <= infilt_pkg::SPECIAL_RESET;
			analog_sel_q <= infilt_pkg::ANALOG_SEL_RESET;
			avg_q <= {2{infilt_pkg::AVG_RESET}};
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else
		begin
			filt_cfg_q <= filt_cfg_d;
			special_q <= special_d;
			analog_sel_q <= analog_sel_d;
			avg_q <= avg_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// discrete input filters

	logic [NUM_INPUTS-1:0] filtered;
	logic [NUM_INPUTS-1:0] input_image_d;
	logic [NUM_INPUTS-1:0] analog_pin;

	assign input_image = input_image_q;

	genvar p;
	generate
		for (p = 0; p < NUM_INPUTS; p++)
		begin : g_pin
			infilt_pkg::filt_cfg_type cfg;
			if (p < infilt_pkg::CONFIG_PINS)
			begin : g_cfg
				// special input functions take the raw pin
				assign cfg.value_ms = filt_cfg_q[(p / infilt_pkg::PINS_PER_GROUP)*4 +: 4];
				assign cfg.bypass = special_q[p / infilt_pkg::PINS_PER_GROUP];
			end
			else
			begin : g_fixed
				assign cfg.value_ms = infilt_pkg::FILT_FIXED_MS;
				assign cfg.bypass = 1'b0;
			end
			if (p >= FIRST_ANALOG_PIN)
			begin : g_shared
				assign analog_pin[p] = analog_sel_q[p - FIRST_ANALOG_PIN];
			end
			else
			begin : g_plain
				assign analog_pin[p] = 1'b0;
			end
			// shared pins keep filtering whenever they are discrete
			pulse_filter u_filter
			(
				.pclk(pclk),
				.presetn(presetn),
				.tick(tick_q),
				.din(pin_level[p]),
				.cfg(cfg),
				.dout(filtered[p])
			);
		end
	endgenerate

	always_comb
	begin
		input_image_d = input_image_q;
		if (scan_end)
		begin
			// analog pins read as off in the discrete image
			input_image_d = filtered & ~analog_pin;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			input_image_q <= '0;
		end
		else
		begin
			input_image_q <= input_image_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// analog averaging, one sample per scan

	genvar c;
	generate
		for (c = 0; c < infilt_pkg::MAX_CHANNELS; c++)
		begin : g_chan
			if (c < CHANNELS)
			begin : g_present
				moving_average #(.DEPTH(AVG_DEPTH)) u_avg
				(
					.pclk(pclk),
					.presetn(presetn),
					.sample_stb(scan_end && analog_sel_q[c]),
					.sample(adc_sample[c]),
					.count(avg_q[c*8 +: 8]),
					.result(result[c])
				);
			end
			else
			begin : g_absent
				assign result[c] = 10'h000;
			end
		end
	endgenerate

endmodule
`default_nettype wire

// ===== test/field_model.sv
// field side model: switch contacts and sensor levels on the inputs
`timescale 1ns/1ps
`default_nettype none
module field_model
#(
	parameter int unsigned N = 32
)
(
	input wire logic pclk,
	output logic [N-1:0] pin_level,
	output logic [infilt_pkg::MAX_CHANNELS-1:0][9:0] adc_sample
);
	initial
	begin
		pin_level = '0;
		adc_sample = '0;
	end
	////////////////////////////////////////////////////////////////
	// contact closed for a number of clocks, then open again
	task automatic pulse(input int pin, input int cycles);
		@(posedge pclk);
		pin_level[pin] <= 1'b1;
		repeat (cycles) @(posedge pclk);
		pin_level[pin] <= 1'b0;
	endtask
	// a sensor may overrange; the block must clip it
	task automatic set_level(input int ch, input logic [9:0] v);
		@(posedge pclk);
		adc_sample[ch] <= v;
	endtask
endmodule
`default_nettype wire

// ===== test/infilt_monitor.sv
// port checker for the input conditioner
`timescale 1ns/1ps
`default_nettype none
module infilt_monitor
#(
	parameter int unsigned NUM_INPUTS = 32
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [NUM_INPUTS-1:0] pin_level,
	input wire logic [infilt_pkg::MAX_CHANNELS-1:0][9:0] adc_sample,
	input wire logic scan_end,
	input wire logic [NUM_INPUTS-1:0] input_image
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_acc;
		psel && penable && !pready;
	endsequence
	sequence s_res;
		paddr[7:5] == 3'h1;
	endsequence
	////////////////////////////////////////////////////////////////
	a_ready_follows: assert property (s_acc |=> pready && psel && penable)
		else $error("no ready after access");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_err_qualified: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_image_hold: assert property (!scan_end |=> $stable(input_image))
		else $error("image changed outside scan end");
	a_image_ro: assert property (s_acc ##0 (pwrite && paddr == infilt_pkg::IMAGE_ADDR) |=> pslverr)
		else $error("image write not refused");
	a_result_ro: assert property (s_acc ##0 s_res ##0 pwrite |=> pslverr)
		else $error("result write not refused");
	a_result_span: assert property (pready && !pwrite ##0 s_res |-> prdata <= 32'h0000_03e8)
		else $error("result above full scale");
	a_cfg_write_ok: assert property (s_acc ##0 (pwrite && paddr == infilt_pkg::FILT_CFG_ADDR) |=> !pslverr)
		else $error("filter setting write refused");
endmodule
////////////////////////////////////////////////////////////////
bind input_conditioner infilt_monitor #(.NUM_INPUTS(NUM_INPUTS)) u_mon (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .pin_level(pin_level), .adc_sample(adc_sample),
	.scan_end(scan_end), .input_image(input_image));
`default_nettype wire

// ===== test/testbench.sv
// self-checking bench for the input conditioner
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, scan_en, step, clr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, seen, input_image;
	wire logic [31:0] pin_level;
	wire logic [infilt_pkg::MAX_CHANNELS-1:0][9:0] adc_sample;
	wire logic scan_end;
	int errors, check_count, scan_cnt;
	input_conditioner #(.TICK_CYCLES(20)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pin_level(pin_level), .adc_sample(adc_sample),
		.scan_end(scan_end), .input_image(input_image));
	field_model u_field (.pclk(pclk), .pin_level(pin_level), .adc_sample(adc_sample));
	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	// scan every ten clocks (half a tick), or single steps
	assign scan_end = (scan_en && scan_cnt == 9) || step;
	always @(posedge pclk)
	begin
		scan_cnt <= (scan_cnt == 9) ? 0 : scan_cnt + 1;
		seen <= clr ? '0 : seen | input_image;
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// request stands until the rising edge that sees ready high;
	// read data and error flag are taken at that very edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic experr);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk({31'h0, pready}, 32'h0000_0001);
		chk({31'h0, err}, {31'h0, experr});
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, '0, 1'b0);
		chk(rd, exp);
	endtask
	task automatic scan();
		@(posedge pclk);
		step <= 1'b1;
		@(posedge pclk);
		step <= 1'b0;
	endtask
	task automatic test_done();
		if (errors == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		{presetn, psel, penable, pwrite, step, clr} = '0;
		paddr = '0;
		pwdata = '0;
		scan_en = 1'b1;
		scan_cnt = 0;
		errors = 0;
		check_count = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rchk(8'h00, 32'h0000_3333);
		rchk(8'h04, '0);
		rchk(8'h08, '0);
		rchk(8'h0c, '0);
		rchk(8'h10, '0);
		rchk(8'h14, '0);
		apb(1'b0, 8'h22, '0, 1'b1);
		apb(1'b1, 8'h10, 32'h0403_0201, 1'b0);
		rchk(8'h10, 32'h0403_0201);
		apb(1'b1, 8'h14, '0, 1'b1);
		apb(1'b1, 8'h20, '0, 1'b1);
		apb(1'b1, 8'h18, '0, 1'b1);
		apb(1'b1, 8'h00, 32'h0000_1308, 1'b0);
		rchk(8'h00, 32'h0000_3308);
		apb(1'b1, 8'h04, 32'h0000_0004, 1'b0);
		clr <= 1'b1;
		@(posedge pclk);
		clr <= 1'b0;
		fork
			u_field.pulse(0, 100);
			u_field.pulse(1, 190);
			u_field.pulse(2, 15);
			u_field.pulse(4, 15);
			u_field.pulse(6, 10);
			u_field.pulse(8, 10);
			u_field.pulse(9, 90);
		join
		repeat (200) @(posedge pclk);
		chk(seen & 32'h0000_03ff, 32'h0000_0216);
		scan_en <= 1'b0;
		apb(1'b1, 8'h08, 32'h0000_0003, 1'b0);
		apb(1'b1, 8'h0c, 32'h0000_0200, 1'b0);
		u_field.set_level(0, 10'h3ff);
		u_field.set_level(1, 10'h064);
		scan();
		rchk(8'h20, 32'h0000_03e8);
		rchk(8'h24, 32'h0000_0064);
		u_field.set_level(0, 10'h1f4);
		u_field.set_level(1, 10'h12c);
		scan();
		rchk(8'h20, 32'h0000_01f4);
		rchk(8'h24, 32'h0000_00c8);
		u_field.set_level(1, 10'h2bc);
		scan();
		rchk(8'h24, 32'h0000_01f4);
		rchk(8'h28, '0);
		// channels 0 and 1 stay analog: pin 24 masked, pins 26 and 27 discrete
		scan_en <= 1'b1;
		clr <= 1'b1;
		@(posedge pclk);
		clr <= 1'b0;
		fork
			u_field.pulse(24, 100);
			u_field.pulse(26, 10);
			u_field.pulse(27, 100);
		join
		repeat (100) @(posedge pclk);
		chk(seen & 32'hff00_0000, 32'h0800_0000);
		test_done();
	end
	initial
	begin
		#50000;
		errors++;
		test_done();
	end
endmodule
`default_nettype wire
